// *** hw/conv_output_end.sv ***
// Converter output end: strap decode, code format, clamp, settling blank,
// strobe beside data. Assumes sample clock and strap arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module conv_output_end
   import conv_pkg::*;
#(
   parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        sample_clock,
   input  wire logic [1:0]  format_stabilizer_select,
   input  wire logic [9:0]  analog_sample,
   output logic             stabilizer_active,
   output logic             twos_format,
   output logic             settling,
   conv_link_if.converter   link
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Every pin passes two flops before logic reads it; the third sample
   // clock flop only feeds the edge detector
   // Reset values match an idle supply-band strap and a low clock
   logic       sclk_m_q, sclk_s_q, sclk_p_q;
   logic [1:0] sel_m_q, sel_s_q;
   logic [9:0] ana_m_q, ana_s_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_m_q <= 1'b0;
         sclk_s_q <= 1'b0;
         sclk_p_q <= 1'b0;
         sel_m_q  <= SEL_RESET;
         sel_s_q  <= SEL_RESET;
      end else if (clk_en) begin
         sclk_m_q <= sample_clock;
         sclk_s_q <= sclk_m_q;
         sclk_p_q <= sclk_s_q;
         sel_m_q  <= format_stabilizer_select;
         sel_s_q  <= sel_m_q;
      end
   end

   // Same latency as the sample clock path, so the code taken at a rise
   // belongs to the level that stood at that rise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ana_m_q <= '0;
         ana_s_q <= '0;
      end else if (clk_en) begin
         ana_m_q <= analog_sample;
         ana_s_q <= ana_m_q;
      end
   end

   // ---------------------------------------------------------------
   // Sample clock edge and period measurement
   // ---------------------------------------------------------------
   // rising edge reference
   wire sclk_rise = sclk_s_q && !sclk_p_q;

   logic [PERIOD_W-1:0] per_cnt_q, last_per_q;
   logic [1:0]          seen_q;
   wire  [PERIOD_W-1:0] per_inc = per_cnt_q + 1'b1;
   // Only a span bounded by two rises is a real period; the span from
   // reset to the first rise would otherwise pass for a speed-up
   wire                 per_known = (seen_q == 2'h2);

   // The counter saturates, so a stopped clock holds the longest period
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         per_cnt_q  <= '0;
         last_per_q <= '1;
         seen_q     <= 2'h0;
      end else if (clk_en) begin
         if (sclk_rise) begin
            last_per_q <= per_inc;
            per_cnt_q  <= '0;
            if (!per_known)
               seen_q <= seen_q + 2'h1;
         end else if (per_cnt_q != '1) begin
            per_cnt_q <= per_inc;
         end
      end
   end

   // ---------------------------------------------------------------
   // Strap decode and stabilizer enable
   // ---------------------------------------------------------------
   // band decode
   wire twos_sel   = band_twos(sel_s_q);
   wire dcs_sel    = band_dcs(sel_s_q);
   // slow clock check; a clock that stops also reads as slow
   wire slow_clock = (last_per_q > PERIOD_W'(DCS_MAX_PERIOD)) ||
                     (per_cnt_q > PERIOD_W'(DCS_MAX_PERIOD));

   logic dcs_q;
   logic twos_q;

   // The strap is re-read every cycle rather than latched at reset, so a
   // board that moves it during bring-up sees the new format at once
   // Enables change with a new strap, a new period measurement or a running count past the limit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dcs_q  <= 1'b0;
         twos_q <= 1'b0;
      end else if (clk_en) begin
         twos_q <= twos_sel;
         dcs_q  <= dcs_sel && !slow_clock;
      end
   end

   assign stabilizer_active = dcs_q;
   assign twos_format       = twos_q;

   // ---------------------------------------------------------------
   // Settling blank after a speed-up
   // ---------------------------------------------------------------
   // Any period one sys cycle shorter than the last counts; sync jitter
   // on a steady clock may then raise a needless blank, which only drops
   // samples and never lets a bad one through
   wire speed_up = sclk_rise && per_known && (per_inc < last_per_q);

   logic [31:0] settle_q;

   // A speed-up seen during a blank restarts the full interval
   // The blank counts sys cycles, so it scales with clk only
   // settling blank after speed-up
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         settle_q <= '0;
      end else if (clk_en) begin
         if (speed_up)
            settle_q <= 32'(SETTLE_CNT);
         else if (settle_q != '0)
            settle_q <= settle_q - 1'b1;
      end
   end

   assign settling = (settle_q != '0);

   // ---------------------------------------------------------------
   // Code forming and output
   // ---------------------------------------------------------------
   // Clamping comes before formatting, so both formats saturate alike
   // Sample is signed, LSB steps; range outside -128..+127 exercises clamping
   wire signed [9:0] samp   = ana_s_q;
   wire [7:0] ob_code = (samp > 10'sd127)  ? CODE_MAX :
                        (samp < -10'sd128) ? CODE_MIN :
                        8'(samp + 10'sd128);

   logic [7:0] data_q;
   logic       strobe_q;

   // code taken at the rising edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_q <= CODE_MID;
      end else if (clk_en) begin
         if (sclk_rise)
            data_q <= fmt_code(ob_code, twos_q);
      end
   end

   // ---------------------------------------------------------------
   // Strobe and link drive
   // ---------------------------------------------------------------
   // strobe follows sample clock
   // The strobe copies the synchronised clock level, so its rise lands on
   // the very edge that loads a new code; a receiver sees data and strobe
   // move together and needs no extra delay on either
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         strobe_q <= 1'b0;
      end else if (clk_en) begin
         strobe_q <= sclk_s_q;
      end
   end

   // A sample clock faster than half of clk aliases in the
   // synchronisers; the strobe then no longer marks every code
   // data and strobe leave from flops on the same edge
   assign link.data                   = data_q;
   assign link.data_strobe_true       = strobe_q;
   assign link.data_strobe_complement = !strobe_q;
endmodule
`default_nettype wire

// *** hw/conv_pkg.sv ***
// Package: shared constants and types for the converter output end
// and the receiver end. Assumes a 200 MHz system clock.
package conv_pkg;
   localparam int unsigned CODE_W         = 8;
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   // Settling interval after a sample clock speed-up
   localparam int unsigned SETTLE_TIME_NS = 5000;
   localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS * 1000) / CLK_PERIOD_PS;
   // Stabilizer lower limit, as a longest sample clock period in sys cycles
   localparam int unsigned DCS_MIN_FREQ_KHZ = 70000;
   localparam int unsigned DCS_MAX_PERIOD   =
      (1000000000 / DCS_MIN_FREQ_KHZ) / CLK_PERIOD_PS;
   localparam int unsigned PERIOD_W       = 16;
   localparam int unsigned FIFO_DEPTH     = 32;
   localparam logic [7:0]  CODE_MID       = 8'h80;
   localparam logic [7:0]  CODE_MAX       = 8'hFF;
   localparam logic [7:0]  CODE_MIN       = 8'h00;
   localparam logic [1:0]  SEL_RESET      = 2'h3;

   // Four strap bands, quantised to two bits: 3 near supply .. 0 near ground
   typedef enum logic [1:0] {
      BAND_GND, BAND_THIRD, BAND_TWO_THIRDS, BAND_SUPPLY
   } strap_band_t;

   // Two's complement for the two lower bands
   function automatic logic band_twos(input logic [1:0] b);
      return (b == 2'h0) || (b == 2'h1);
   endfunction

   // Stabilizer on only in the two middle bands
   function automatic logic band_dcs(input logic [1:0] b);
      return (b == 2'h1) || (b == 2'h2);
   endfunction

   // Formats differ only in the top bit
   function automatic logic [7:0] fmt_code(input logic [7:0] ob, input logic twos);
      return {ob[7] ^ twos, ob[6:0]};
   endfunction
endpackage

// *** hw/conv_link_if.sv ***
// Interface: parallel byte plus differential strobe between the two ends.
// Assumes the receiver end reads the pins through the receiver modport; the bench reads them directly.
`timescale 1ns/1ps
`default_nettype none
interface conv_link_if;
   logic [7:0] data;
   logic       data_strobe_true;
   logic       data_strobe_complement;

   modport converter (output data, output data_strobe_true, output data_strobe_complement);
   modport receiver  (input data, input data_strobe_true, input data_strobe_complement);
endinterface
`default_nettype wire

// *** hw/sample_fifo.sv ***
// FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (clk_en) begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// *** hw/conv_receiver_end.sv ***
// Receiver end: latches bytes on strobe rise, restores offset binary,
// drops samples during settling, buffers in a FIFO.
// Assumes the strobe pins arrive asynchronously to clk.
`timescale 1ns/1ps
`default_nettype none
module conv_receiver_end
   import conv_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        twos_static,
   input  wire logic        discard,
   conv_link_if.receiver    link,
   output logic [7:0]       sample_data,
   output logic             sample_valid,
   input  wire logic        sample_ready,
   output logic             overrun
);
   logic       st_m_q, st_s_q, st_p_q;
   logic [7:0] d_m_q, d_s_q;
   logic       ov_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_m_q <= 1'b0;
         st_s_q <= 1'b0;
         st_p_q <= 1'b0;
         d_m_q  <= CODE_MID;
         d_s_q  <= CODE_MID;
      end else if (clk_en) begin
         st_m_q <= link.data_strobe_true && !link.data_strobe_complement;
         st_s_q <= st_m_q;
         st_p_q <= st_s_q;
         d_m_q  <= link.data;
         d_s_q  <= d_m_q;
      end
   end

   wire        cap      = st_s_q && !st_p_q;
   wire [7:0]  ob       = fmt_code(d_s_q, twos_static);
   wire        push     = cap && !discard;
   wire        in_ready;

   always_ff @(posedge clk) begin
      if (sys_rst)
         ov_q <= 1'b0;
      else if (clk_en && push && !in_ready)
         ov_q <= 1'b1;
   end
   assign overrun = ov_q;

   // time order kept by a single in-order queue
   sample_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .in_data   (ob),
      .in_valid  (push),
      .in_ready  (in_ready),
      .out_data  (sample_data),
      .out_valid (sample_valid),
      .out_ready (sample_ready)
   );
endmodule
`default_nettype wire

// *** testbench/conv_link_sva.sv ***
// Checker for the byte link between the converter and receiver ends.
// Assumes one clk domain and link pins launched from flops.
`timescale 1ns/1ps
`default_nettype none
module conv_link_sva (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] data,
   input  wire logic       data_strobe_true,
   input  wire logic       data_strobe_complement
);
   // ------------------------------
   // Link properties
   // ------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_launch;
      $rose(data_strobe_true);
   endsequence
   sequence s_release;
      $fell(sys_rst) ##1 !$rose(data_strobe_true);
   endsequence
   a_strobe_pair: assert property (data_strobe_complement == !data_strobe_true)
      else $error("strobe pins not complementary");
   a_compl_edge: assert property (s_launch |-> $fell(data_strobe_complement))
      else $error("complement strobe did not fall with true");
   a_data_launch: assert property ($changed(data) |-> $rose(data_strobe_true))
      else $error("data changed without strobe rise");
   a_data_stands: assert property (s_launch |=> $stable(data))
      else $error("data moved right after launch");
   a_fall_quiet: assert property ($fell(data_strobe_true) |-> $stable(data))
      else $error("data moved on strobe fall");
   a_single_rise: assert property (s_launch |=> !$rose(data_strobe_true))
      else $error("strobe rose twice in a row");
   a_reset_idle: assert property ($fell(sys_rst) |-> data == 8'h80 && !data_strobe_true)
      else $error("link not idle after reset");
   a_idle_code: assert property (s_release |-> data == 8'h80)
      else $error("mid code lost before first launch");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Bench: both ends joined by the link; drives sample clock, strap,
// analog level and the receiver user side. Assumes a 200 MHz clk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: %0h vs %0h", $time, a, b); end end
module tb;
   logic       clk = 0;
   logic       sys_rst = 1;
   logic       sc = 0;
   logic [1:0] strap = 2'h3;
   logic [9:0] analog = '0;
   logic       twos_static = 0;
   logic       drop = 1;
   logic       sample_ready = 0;
   logic       stab, twos, settling, sample_valid, overrun;
   logic [7:0] sample_data;
   wire logic  discard;
   int         fails = 0;
   int         checks = 0;
   int         sc_half = 40;
   conv_link_if link ();
   assign discard = settling | drop;
   conv_output_end #(.SETTLE_CNT(20)) conv_output_end_inst (.clk(clk), .sys_rst(sys_rst),
      .clk_en(1'b1), .sample_clock(sc), .format_stabilizer_select(strap),
      .analog_sample(analog), .stabilizer_active(stab), .twos_format(twos),
      .settling(settling), .link(link));
   conv_receiver_end conv_receiver_end_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .twos_static(twos_static), .discard(discard), .link(link), .sample_data(sample_data),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .overrun(overrun));
   conv_link_sva link_chk (.clk(clk), .sys_rst(sys_rst), .data(link.data),
      .data_strobe_true(link.data_strobe_true),
      .data_strobe_complement(link.data_strobe_complement));
   // ------------------------------
   // Clocks and helpers
   // ------------------------------
   initial forever #2.5 clk = ~clk;
   // Offset keeps sample edges clear of clk edges
   initial begin
      #3;
      forever #(sc_half) sc = ~sc;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rises(input int n);
      repeat (n) @(posedge link.data_strobe_true);
      step(1);
   endtask
   task automatic drain(input logic [7:0] e, input bit cmp, output int n);
      n = 0;
      while (sample_valid === 1'b1) begin
         if (cmp) `CHK(sample_data, e)
         sample_ready = 1;
         step(1);
         n++;
      end
      sample_ready = 0;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset();
      sys_rst = 1;
      step(10);
      sys_rst = 0;
      `CHK({link.data, link.data_strobe_true, link.data_strobe_complement}, 10'h201)
      `CHK({settling, stab, sample_valid, overrun}, 4'h0)
   endtask
   task automatic t_codes();
      int v[7] = '{-300, -128, -1, 0, 1, 127, 200};
      logic [7:0] e[7] = '{8'h00, 8'h00, 8'h7F, 8'h80, 8'h81, 8'hFF, 8'hFF};
      int n;
      for (int f = 0; f < 2; f++) begin
         strap = f ? 2'h0 : 2'h3;
         twos_static = f[0];
         for (int i = 0; i < 7; i++) begin
            analog = v[i][9:0];
            rises(2);
            `CHK(link.data, e[i] ^ {f[0], 7'h00})
            drop = 0;
            rises(1);
            drop = 1;
            step(8);
            drain(e[i], 1, n);
            `CHK(n > 0, 1'b1)
         end
      end
   endtask
   task automatic t_clock();
      int n;
      strap = 2'h2;
      // Switch in the low half so the period shortens in one step only
      @(negedge sc);
      step(1);
      sc_half = 20;
      n = 0;
      while (settling !== 1'b1 && n < 60) begin
         step(1);
         n++;
      end
      `CHK(settling, 1'b1)
      n = 0;
      while (settling === 1'b1) begin
         step(1);
         n++;
      end
      `CHK((n >= 19) && (n <= 21), 1'b1)
      sc_half = 5;
      for (int b = 0; b < 4; b++) begin
         strap = b[1:0];
         step(30);
         `CHK({stab, twos}, {(b == 1) || (b == 2), b < 2})
      end
      strap = 2'h2;
      sc_half = 40;
      rises(3);
      `CHK(stab, 1'b0)
   endtask
   task automatic t_overrun();
      int n;
      drop = 0;
      rises(34);
      drop = 1;
      step(8);
      `CHK(overrun, 1'b1)
      drain(8'h00, 0, n);
      `CHK(n, 32)
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      t_reset();
      t_codes();
      t_clock();
      t_overrun();
      t_reset();
      conclude();
   end
   // Run needs about 1500 cycles; hang cut well beyond that
   initial begin
      step(20000);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
